// [logic/pldp_defines.vh]
// Contract
// - Palette holds 256 entries of 18 bits: 6 red, 6 green, 6 blue.
// - Pixel index and blank sampled each clock; outputs follow three edges later.
// - Sampled pixel index selects the table entry feeding the three colour outputs; the code ANDs the index with pixel_index_mask before the lookup.
// - Blank forces all three colour outputs to zero regardless of index.
// - Host port timed only by its own write and read strobes; the code samples both strobes on clk and acts on their rising edges.
// - Write to write-mode index port loads index and arms write mode.
// - Write mode gathers red, green, blue data bytes, low 6 bits each.
// - Third write byte stores holding value at index, then index increments.
// - Write to read-mode index port loads index, fetches entry, increments index.
// - Read mode returns red, green, blue; third read fetches next entry, increments.
// - Index port write mid-triplet abandons it and restarts at first colour.
// - Mode status reads zeros in bits 0,1 in read mode, ones in write.
// - Index and status reads have no side effects and are always accepted.
`ifndef PLDP_DEFINES_VH
`define PLDP_DEFINES_VH
`define PLDP_ADDR_MASK       10'h3c6
`define PLDP_ADDR_RD_INDEX   10'h3c7
`define PLDP_ADDR_WR_INDEX   10'h3c8
`define PLDP_ADDR_DATA       10'h3c9
`define PLDP_MASK_RESET      8'hff
`define PLDP_STATE_RD        8'h00
`define PLDP_STATE_WR        8'h03
`define PLDP_PIPE_DEPTH      3
`define PLDP_STROBE_GAP_NS   240
`define PLDP_CLK_NS          10
`define PLDP_RED_LSB         12
`define PLDP_GRN_LSB         6
`define PLDP_BLU_LSB         0
`endif

// [logic/pldp_palette.v]
`timescale 1ns/100ps
`default_nettype none
`include "pldp_defines.vh"
module pldp_palette #(
   parameter ENTRIES = 256,
   parameter CW      = 6
) (
   input  wire          clk,
   input  wire          nrst,
   input  wire [7:0]    pixel_index_in,
   input  wire          blank_in,
   output reg  [CW-1:0] red_out,
   output reg  [CW-1:0] green_out,
   output reg  [CW-1:0] blue_out,
   output wire          pixel_ready,
   input  wire [9:0]    host_addr,
   input  wire          host_wr,
   input  wire          host_rd,
   input  wire [7:0]    host_wdata,
   output reg  [7:0]    host_rdata
);
   localparam EW = 3 * CW;

   localparam SEQ_RED = 2'd0;
   localparam SEQ_GRN = 2'd1;
   localparam SEQ_BLU = 2'd2;

   reg [EW-1:0] table_mem [0:ENTRIES-1];
   reg [7:0]    pixel_index_mask;
   reg [7:0]    palette_index;
   reg          write_mode;
   reg [1:0]    seq_pos;
   reg [EW-1:0] hold;
   reg          wr_q;
   reg          rd_q;

   reg [7:0]    s1_index;
   reg          s1_blank;
   reg          s1_valid;
   reg [EW-1:0] s2_colour;
   reg          s2_blank;
   reg          s2_valid;
   wire         buf_ready;
   wire         out_valid;
   wire [EW:0]  out_word;
   reg  [7:0]   next_index;
   integer      i;

   function [7:0] pldp_pick;
      input [EW-1:0] entry;
      input [1:0]    pos;
      begin
         case (pos)
            SEQ_RED: pldp_pick = {2'b00, entry[`PLDP_RED_LSB +: CW]};
            SEQ_GRN: pldp_pick = {2'b00, entry[`PLDP_GRN_LSB +: CW]};
            default: pldp_pick = {2'b00, entry[`PLDP_BLU_LSB +: CW]};
         endcase
      end
   endfunction

   // Strobes are edge-detected so a held strobe acts once.
   wire wr_ev = host_wr & ~wr_q;
   wire rd_ev = host_rd & ~rd_q;
   wire wr_mask  = wr_ev && host_addr == `PLDP_ADDR_MASK;
   wire wr_ridx  = wr_ev && host_addr == `PLDP_ADDR_RD_INDEX;
   wire wr_widx  = wr_ev && host_addr == `PLDP_ADDR_WR_INDEX;
   wire wr_data  = wr_ev && host_addr == `PLDP_ADDR_DATA;
   wire rd_data  = rd_ev && host_addr == `PLDP_ADDR_DATA;

   assign pixel_ready = buf_ready;

   always @* begin
      next_index = palette_index + 8'h01;
   end

   // Host side.
   always @(posedge clk) begin
      if (!nrst) begin
         wr_q             <= 1'b0;
         rd_q             <= 1'b0;
         pixel_index_mask <= `PLDP_MASK_RESET;
         palette_index    <= 8'h00;
         write_mode       <= 1'b1;
         seq_pos          <= SEQ_RED;
         hold             <= {EW{1'b0}};
         host_rdata       <= 8'h00;
      end else begin
         wr_q <= host_wr;
         rd_q <= host_rd;
         if (wr_mask) begin
            pixel_index_mask <= host_wdata;
         end
         if (wr_widx) begin
            palette_index <= host_wdata;
            write_mode    <= 1'b1;
            seq_pos       <= SEQ_RED;
         end else if (wr_ridx) begin
            hold          <= table_mem[host_wdata];
            palette_index <= host_wdata + 8'h01;
            write_mode    <= 1'b0;
            seq_pos       <= SEQ_RED;
         end else if (wr_data && write_mode) begin
            case (seq_pos)
               SEQ_RED: begin
                  hold[`PLDP_RED_LSB +: CW] <= host_wdata[CW-1:0];
                  seq_pos <= SEQ_GRN;
               end
               SEQ_GRN: begin
                  hold[`PLDP_GRN_LSB +: CW] <= host_wdata[CW-1:0];
                  seq_pos <= SEQ_BLU;
               end
               default: begin
                  palette_index <= next_index;
                  seq_pos       <= SEQ_RED;
               end
            endcase
         end
         if (rd_ev) begin
            // Index and status reads change no sequence state.
            case (host_addr)
               `PLDP_ADDR_MASK:     host_rdata <= pixel_index_mask;
               `PLDP_ADDR_RD_INDEX: host_rdata <= write_mode ?
                  `PLDP_STATE_WR : `PLDP_STATE_RD;
               `PLDP_ADDR_WR_INDEX: host_rdata <= palette_index;
               `PLDP_ADDR_DATA:     host_rdata <= pldp_pick(hold, seq_pos);
               default:             host_rdata <= 8'h00;
            endcase
         end
         if (rd_data && !write_mode) begin
            if (seq_pos == SEQ_BLU) begin
               hold          <= table_mem[palette_index];
               palette_index <= next_index;
               seq_pos       <= SEQ_RED;
            end else begin
               seq_pos <= seq_pos + 2'd1;
            end
         end
      end
   end

   // Table write: the blue byte completes the holding value in the same edge.
   always @(posedge clk) begin
      if (!nrst) begin
         for (i = 0; i < ENTRIES; i = i + 1) begin
            table_mem[i] <= {EW{1'b0}};
         end
      end else if (wr_data && write_mode && seq_pos == SEQ_BLU &&
                   !wr_widx && !wr_ridx) begin
         table_mem[palette_index] <= {hold[EW-1:CW],
                                      host_wdata[CW-1:0]};
      end
   end

   // Pixel pipeline: sample, look up, buffer, output register.
   always @(posedge clk) begin
      if (!nrst) begin
         s1_index  <= 8'h00;
         s1_blank  <= 1'b1;
         s1_valid  <= 1'b0;
         s2_colour <= {EW{1'b0}};
         s2_blank  <= 1'b1;
         s2_valid  <= 1'b0;
      end else if (buf_ready) begin
         s1_index  <= pixel_index_in & pixel_index_mask;
         s1_blank  <= blank_in;
         s1_valid  <= 1'b1;
         s2_colour <= table_mem[s1_index];
         s2_blank  <= s1_blank;
         s2_valid  <= s1_valid;
      end
   end

   pldp_skid_buffer #(
      .WIDTH (EW + 1)
   ) u_buf (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (s2_valid),
      .in_ready  (buf_ready),
      .in_data   ({s2_blank, s2_colour}),
      .out_valid (out_valid),
      .out_ready (1'b1),
      .out_data  (out_word)
   );

   always @(posedge clk) begin
      if (!nrst) begin
         red_out   <= {CW{1'b0}};
         green_out <= {CW{1'b0}};
         blue_out  <= {CW{1'b0}};
      end else if (!out_valid || out_word[EW]) begin
         red_out   <= {CW{1'b0}};
         green_out <= {CW{1'b0}};
         blue_out  <= {CW{1'b0}};
      end else begin
         red_out   <= out_word[`PLDP_RED_LSB +: CW];
         green_out <= out_word[`PLDP_GRN_LSB +: CW];
         blue_out  <= out_word[`PLDP_BLU_LSB +: CW];
      end
   end
endmodule
`default_nettype wire

// [logic/pldp_skid_buffer.v]
`timescale 1ns/100ps
`default_nettype none
module pldp_skid_buffer #(
   parameter WIDTH = 19
) (
   input  wire             clk,
   input  wire             nrst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   // Two entries, so a stall by the receiver loses no word.
   reg [WIDTH-1:0] mem [0:1];
   reg             wr_ptr;
   reg             rd_ptr;
   reg [1:0]       count;
   wire            push;
   wire            pop;

   assign in_ready  = (count != 2'd2);
   assign out_valid = (count != 2'd0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk) begin
      if (!nrst) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'd0;
         mem[0] <= {WIDTH{1'b0}};
         mem[1] <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         if (push && !pop) begin
            count <= count + 2'd1;
         end else if (pop && !push) begin
            count <= count - 2'd1;
         end
      end
   end
endmodule
`default_nettype wire

// [verification/pldp_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pldp_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] host_rdata,
   output var  logic [9:0] host_addr,
   output var  logic       host_wr,
   output var  logic       host_rd,
   output var  logic [7:0] host_wdata
);
   initial begin
      host_addr = 10'h000;
      host_wdata = 8'h00;
      host_wr = 1'b0;
      host_rd = 1'b0;
   end
   // Released lines are inverted so a stale value can never look valid.
   task automatic gap();
      host_addr = ~host_addr;
      host_wdata = ~host_wdata;
      repeat (24) @(negedge clk);
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(negedge clk);
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      @(negedge clk);
      host_wr = 1'b0;
      gap();
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(negedge clk);
      host_addr = a;
      host_rd = 1'b1;
      repeat (2) @(negedge clk);
      d = host_rdata;
      host_rd = 1'b0;
      gap();
   endtask
endmodule
`default_nettype wire

// [verification/pldp_palette_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module pldp_palette_sva (
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic       blank_in,
   input wire logic [5:0] red_out,
   input wire logic [5:0] green_out,
   input wire logic [5:0] blue_out,
   input wire logic       pixel_ready,
   input wire logic [9:0] host_addr,
   input wire logic       host_wr,
   input wire logic       host_rd,
   input wire logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata
);
   logic       wr_d, rd_d, wmode;
   logic [7:0] mask;
   wire        wtk = host_wr & ~wr_d;
   wire        rtk = host_rd & ~rd_d;
   wire        dark = (red_out | green_out | blue_out) == 6'h00;
   // Mode and mask are tracked here so status and mask reads can be judged.
   always_ff @(posedge clk) begin
      wr_d <= host_wr;
      rd_d <= host_rd;
      if (!nrst) begin
         wmode <= 1'b1;
         mask  <= 8'hff;
      end else if (wtk) begin
         case (host_addr)
            10'h3c6: mask <= host_wdata;
            10'h3c7: wmode <= 1'b0;
            10'h3c8: wmode <= 1'b1;
            default: ;
         endcase
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Blank sampled at one edge reaches the output register three edges
   // later, so the checker sees it in the sampled values one edge after that.
   a_blank_dark: assert property (blank_in |-> ##4 dark)
      else $error("colours not dark four edges after blank");
   a_pixel_ready: assert property (pixel_ready)
      else $error("pixel path stopped accepting");
   a_status_mode: assert property (rtk && host_addr == 10'h3c7 |=>
      host_rdata == (wmode ? 8'h03 : 8'h00))
      else $error("mode status byte wrong");
   a_mask_read: assert property (rtk && host_addr == 10'h3c6 |=>
      host_rdata == mask)
      else $error("mask readback wrong");
   a_rdata_hold: assert property (!rtk |=> $stable(host_rdata))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (rtk && (host_addr < 10'h3c6 ||
      host_addr > 10'h3c9) |=> host_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_data_low6: assert property (rtk && host_addr == 10'h3c9 |=>
      host_rdata[7:6] == 2'b00)
      else $error("colour byte upper bits set");
   a_reset_dark: assert property ($rose(nrst) |-> dark && host_rdata == 8'h00)
      else $error("outputs not cleared by reset");
   cover property (blank_in ##4 dark);
   cover property (rtk && host_addr == 10'h3c9);
   cover property (rtk && host_addr == 10'h3c7 && !wmode);
   cover property (wtk && host_addr == 10'h3c8);
endmodule
bind pldp_palette pldp_palette_sva pldp_palette_sva_inst (.clk(clk),
   .nrst(nrst), .blank_in(blank_in), .red_out(red_out),
   .green_out(green_out), .blue_out(blue_out), .pixel_ready(pixel_ready),
   .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
   .host_wdata(host_wdata), .host_rdata(host_rdata));
`default_nettype wire

// [verification/pldp_palette_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module pldp_palette_tb;
   logic       clk, nrst, blank_in, host_wr, host_rd, pixel_ready;
   logic [7:0] pixel_index_in, host_wdata, host_rdata, v;
   logic [9:0] host_addr;
   logic [5:0] red_out, green_out, blue_out;
   int         fails, check_count;
   pldp_palette pldp_palette_inst (.clk(clk), .nrst(nrst),
      .pixel_index_in(pixel_index_in), .blank_in(blank_in),
      .red_out(red_out), .green_out(green_out), .blue_out(blue_out),
      .pixel_ready(pixel_ready), .host_addr(host_addr), .host_wr(host_wr),
      .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata));
   pldp_host_model pldp_host_model_inst (.clk(clk), .host_rdata(host_rdata),
      .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
      .host_wdata(host_wdata));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic w(input logic [9:0] a, input logic [7:0] d);
      pldp_host_model_inst.wr(a, d);
   endtask
   task automatic r(input logic [9:0] a);
      pldp_host_model_inst.rd(a, v);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic t_reset();
      r(10'h3c6);
      chk("mask", 8'hff, v);
      r(10'h3c7);
      chk("state", 8'h03, v);
      r(10'h3c8);
      chk("index", 8'h00, v);
      r(10'h3c5);
      chk("unmapped", 8'h00, v);
   endtask
   task automatic t_wrap();
      logic [47:0] ex;
      ex = 48'h3f0102050607;
      w(10'h3c8, 8'hfe);
      w(10'h3c9, 8'hff);
      w(10'h3c9, 8'h41);
      w(10'h3c9, 8'h02);
      w(10'h3c9, 8'h05);
      w(10'h3c9, 8'h06);
      w(10'h3c9, 8'h07);
      r(10'h3c8);
      chk("index wrap", 8'h00, v);
      w(10'h3c7, 8'hfe);
      r(10'h3c7);
      chk("state", 8'h00, v);
      for (int i = 0; i < 6; i++) begin
         r(10'h3c9);
         chk("colour byte", ex[47 - 8 * i -: 8], v);
      end
      r(10'h3c8);
      chk("index", 8'h01, v);
   endtask
   task automatic t_abort();
      w(10'h3c8, 8'h10);
      w(10'h3c9, 8'h2a);
      w(10'h3c9, 8'h2b);
      w(10'h3c8, 8'h10);
      w(10'h3c9, 8'h01);
      w(10'h3c9, 8'h02);
      w(10'h3c9, 8'h03);
      r(10'h3c7);
      chk("state back", 8'h03, v);
      w(10'h3c7, 8'h10);
      r(10'h3c9);
      chk("red read", 8'h01, v);
      w(10'h3c7, 8'h10);
      r(10'h3c9);
      chk("red again", 8'h01, v);
      r(10'h3c9);
      chk("green read", 8'h02, v);
      r(10'h3c9);
      chk("blue read", 8'h03, v);
      @(negedge clk);
      pixel_index_in = 8'h00;
      blank_in = 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      pixel_index_in = 8'h10;
      repeat (3) @(posedge clk);
      #1 chk("red early", 8'h00, {2'b00, red_out});
      @(posedge clk);
      #1 chk("red", 8'h01, {2'b00, red_out});
      chk("green", 8'h02, {2'b00, green_out});
      chk("blue", 8'h03, {2'b00, blue_out});
      @(negedge clk);
      blank_in = 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("red before blank", 8'h01, {2'b00, red_out});
      @(posedge clk);
      #1 chk("red blanked", 8'h00, {2'b00, red_out});
   endtask
   task automatic t_mask();
      w(10'h3c6, 8'h1f);
      r(10'h3c6);
      chk("mask", 8'h1f, v);
      @(negedge clk);
      pixel_index_in = 8'hf0;
      blank_in = 1'b0;
      repeat (4) @(posedge clk);
      #1 chk("masked red", 8'h01, {2'b00, red_out});
      chk("masked green", 8'h02, {2'b00, green_out});
      chk("masked blue", 8'h03, {2'b00, blue_out});
      // The mask goes back to all ones, as reset leaves it.
      w(10'h3c6, 8'hff);
      r(10'h3c6);
      chk("mask restored", 8'hff, v);
   endtask
   initial begin
      fails = 0;
      check_count = 0;
      nrst = 1'b0;
      blank_in = 1'b1;
      pixel_index_in = 8'h00;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      t_reset();
      t_wrap();
      t_abort();
      t_mask();
      give_verdict();
   end
   initial begin
      #100000;
      fails++;
      $display("[ERR] watchdog expected finish seen timeout");
      give_verdict();
   end
endmodule
`default_nettype wire
